// ===== logic/mgr_routing_regs.sv
// multicast group routing configuration registers with hit, group, block and overlay logic
// Summary of operation
// R01 - Read-only six-bit supported group limit, encoded count minus one.
// R02 - Endpoints report requested window size log2 in bits 13:8.
// R03 - Bit 15 of capability set only when crc regeneration is possible.
// R04 - Writable configured group count, count minus one, resets to zero.
// R05 - Software keeps configured group count at or below the supported limit.
// R06 - Configured group count sets upper end of multicast window above base.
// R07 - Configured group count is ignored while multicast is off.
// R08 - Control bit 15 enables multicast handling, resets to zero.
// R09 - Writable six-bit group field lsb position, reset zero.
// R10 - Software keeps group field lsb at 12 or more when enabled.
// R11 - Window base held in bits 63:12 of base register, reset zero.
// R12 - Software zeros base bits inside or below the group field.
// R13 - Accept vector bit set: take or forward packets of that group.
// R14 - Vector bits above configured count ignored; all vectors reset zero.
// R15 - Block vector bit set: function may not send to that group.
// R16 - Untranslated block bit set: no untranslated sends to that group.
// R17 - Endpoints without translation may keep untranslated vector reserved.
// R18 - Switch and root ports implement overlay register; endpoints do not.
// R19 - Software finds overlay register presence from the port type field.
// R20 - Egress multicast packets get their address replaced onto unicast window.
// R21 - Overlay size six or more gives aperture log2; below six disables.
// R22 - Overlay register bits 63:6 hold overlay window base, reset zero.
// R23 - Software programs shared fields identically in every structure.
// R24 - Hit when base <= address < base + groups << lsb; group is offset >> lsb.
// R25 - Overlay replaces address bits at and above size with overlay base bits.
`timescale 1ns/1ps
`include "mgr_consts.svh"
module mgr_routing_regs #(
  parameter mgr_pkg::mgr_port_kind_t PORT_KIND = mgr_pkg::MGR_PORT_SWITCH,
  parameter logic [5:0] SUPPORTED_GROUP_LIMIT = 6'h3F,
  parameter logic [5:0] WINDOW_SIZE_REQUEST = 6'h00,
  parameter logic CRC_REGEN_CAPABLE = 1'b0,
  parameter logic HAS_TRANSLATION = 1'b1
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_clk_en,
  input wire logic i_cfg_wr,
  input wire logic i_cfg_rd,
  input wire logic [11:0] i_cfg_addr,
  input wire logic [31:0] i_cfg_wdata,
  input wire logic [3:0] i_cfg_be,
  output logic [31:0] o_cfg_rdata,
  input wire logic i_req_valid,
  input wire logic i_req_posted,
  input wire logic i_req_untranslated,
  input wire logic i_req_egress,
  input wire logic [63:0] i_req_addr,
  output logic o_mc_hit,
  output logic [5:0] o_mc_group,
  output logic o_mc_accept,
  output logic o_mc_send_blocked,
  output logic [63:0] o_out_addr
);
  // endpoints keep the overlay pair, and without translation the untranslated vector, at zero
  localparam logic IS_PORT = (PORT_KIND != mgr_pkg::MGR_PORT_ENDPOINT);
  localparam logic UNTR_WRITABLE = IS_PORT || HAS_TRANSLATION;

  logic multicast_on_r, multicast_on_nxt;
  logic [5:0] configured_group_count_r, configured_group_count_nxt;
  logic [5:0] group_field_lsb_r, group_field_lsb_nxt;
  logic [63:12] window_base_r, window_base_nxt;
  logic [63:0] group_accept_vector_r, group_accept_vector_nxt;
  logic [63:0] group_send_block_r, group_send_block_nxt;
  logic [63:0] untranslated_send_block_r, untranslated_send_block_nxt;
  logic [63:6] overlay_base_r, overlay_base_nxt;
  logic [5:0] overlay_size_log2_r, overlay_size_log2_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic hit_r, hit_nxt;
  logic [5:0] group_r, group_nxt;
  logic accept_r, accept_nxt;
  logic blocked_r, blocked_nxt;
  logic [63:0] out_addr_r, out_addr_nxt;

  // byte-lane merge of a 32-bit write into a stored word
  function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_be

  // mask of vector bits 0..top, for the supported limit or the configured group count
  function automatic logic [63:0] limit_mask(input logic [5:0] top);
    logic [63:0] m;
    m = '0;
    for (int i = 0; i < 64; i++)
    begin
      m[i] = (6'(i) <= top);
    end
    return m;
  endfunction : limit_mask

  // vector bits above the supported limit are not stored
  localparam logic [63:0] IMPL_MASK = limit_mask(SUPPORTED_GROUP_LIMIT);

  // register write path
  always_comb
  begin
    logic [31:0] cur;
    logic [31:0] nw;
    cur = '0;
    nw = '0;
    multicast_on_nxt = multicast_on_r;
    configured_group_count_nxt = configured_group_count_r;
    group_field_lsb_nxt = group_field_lsb_r;
    window_base_nxt = window_base_r;
    group_accept_vector_nxt = group_accept_vector_r;
    group_send_block_nxt = group_send_block_r;
    untranslated_send_block_nxt = untranslated_send_block_r;
    overlay_base_nxt = overlay_base_r;
    overlay_size_log2_nxt = overlay_size_log2_r;
    if (i_cfg_wr)
    begin
      unique case (i_cfg_addr)
        `MGR_OFF_CAP_CTRL:
        begin
          cur = {multicast_on_r, 9'h000, configured_group_count_r, 16'h0000};
          nw = merge_be(cur, i_cfg_wdata, i_cfg_be);
          multicast_on_nxt = nw[16 + `MGR_CTRL_ENABLE_BIT]; // R08
          configured_group_count_nxt = nw[21:16]; // R04
        end
        `MGR_OFF_BASE_LO:
        begin
          cur = {window_base_r[31:12], 6'h00, group_field_lsb_r};
          nw = merge_be(cur, i_cfg_wdata, i_cfg_be);
          group_field_lsb_nxt = nw[5:0]; // R09
          window_base_nxt[31:12] = nw[31:12]; // R11
        end
        `MGR_OFF_BASE_HI:
        begin
          window_base_nxt[63:32] = merge_be(window_base_r[63:32], i_cfg_wdata, i_cfg_be); // R11
        end
        `MGR_OFF_ACCEPT_LO:
          group_accept_vector_nxt[31:0] = merge_be(group_accept_vector_r[31:0], i_cfg_wdata, i_cfg_be) & IMPL_MASK[31:0];
        `MGR_OFF_ACCEPT_HI:
          group_accept_vector_nxt[63:32] =
            merge_be(group_accept_vector_r[63:32], i_cfg_wdata, i_cfg_be) & IMPL_MASK[63:32];
        `MGR_OFF_BLOCK_LO:
          group_send_block_nxt[31:0] = merge_be(group_send_block_r[31:0], i_cfg_wdata, i_cfg_be) & IMPL_MASK[31:0];
        `MGR_OFF_BLOCK_HI:
          group_send_block_nxt[63:32] = merge_be(group_send_block_r[63:32], i_cfg_wdata, i_cfg_be) & IMPL_MASK[63:32];
        `MGR_OFF_UNTR_LO:
        begin
          if (UNTR_WRITABLE) // R17
          begin
            untranslated_send_block_nxt[31:0] =
              merge_be(untranslated_send_block_r[31:0], i_cfg_wdata, i_cfg_be) & IMPL_MASK[31:0];
          end
        end
        `MGR_OFF_UNTR_HI:
        begin
          if (UNTR_WRITABLE) // R17
          begin
            untranslated_send_block_nxt[63:32] =
              merge_be(untranslated_send_block_r[63:32], i_cfg_wdata, i_cfg_be) & IMPL_MASK[63:32];
          end
        end
        `MGR_OFF_OVL_LO:
        begin
          if (IS_PORT) // R18
          begin
            cur = {overlay_base_r[31:6], overlay_size_log2_r};
            nw = merge_be(cur, i_cfg_wdata, i_cfg_be);
            overlay_size_log2_nxt = nw[5:0]; // R21
            overlay_base_nxt[31:6] = nw[31:6]; // R22
          end
        end
        `MGR_OFF_OVL_HI:
        begin
          if (IS_PORT) // R18
          begin
            overlay_base_nxt[63:32] = merge_be(overlay_base_r[63:32], i_cfg_wdata, i_cfg_be); // R22
          end
        end
        default:
        begin
        end
      endcase
    end
  end

  // read path, unmapped offsets read zero
  always_comb
  begin
    rdata_nxt = rdata_r;
    if (i_cfg_rd)
    begin
      unique case (i_cfg_addr)
        `MGR_OFF_CAP_CTRL:
          rdata_nxt = {multicast_on_r, 9'h000, configured_group_count_r,
                       CRC_REGEN_CAPABLE, 1'b0, (IS_PORT ? 6'h00 : WINDOW_SIZE_REQUEST), // R01 R02 R03
                       2'b00, SUPPORTED_GROUP_LIMIT};
        `MGR_OFF_BASE_LO: rdata_nxt = {window_base_r[31:12], 6'h00, group_field_lsb_r};
        `MGR_OFF_BASE_HI: rdata_nxt = window_base_r[63:32];
        `MGR_OFF_ACCEPT_LO: rdata_nxt = group_accept_vector_r[31:0];
        `MGR_OFF_ACCEPT_HI: rdata_nxt = group_accept_vector_r[63:32];
        `MGR_OFF_BLOCK_LO: rdata_nxt = group_send_block_r[31:0];
        `MGR_OFF_BLOCK_HI: rdata_nxt = group_send_block_r[63:32];
        `MGR_OFF_UNTR_LO: rdata_nxt = untranslated_send_block_r[31:0];
        `MGR_OFF_UNTR_HI: rdata_nxt = untranslated_send_block_r[63:32];
        `MGR_OFF_OVL_LO: rdata_nxt = {overlay_base_r[31:6], overlay_size_log2_r};
        `MGR_OFF_OVL_HI: rdata_nxt = overlay_base_r[63:32];
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // request classification and address overlay
  always_comb
  begin
    logic [63:0] base;
    logic [63:0] top;
    logic [63:0] offs;
    logic [63:0] grp;
    logic [63:0] lo_mask;
    logic [63:0] active;
    base = {window_base_r, 12'h000};
    // window end wraps whenever the window reaches the top of the 64-bit address space
    top = base + ({58'h0, configured_group_count_r} + 64'h1 << group_field_lsb_r); // R06
    offs = i_req_addr - base;
    grp = offs >> group_field_lsb_r; // R24
    lo_mask = (64'h1 << overlay_size_log2_r) - 64'h1;
    active = limit_mask(configured_group_count_r); // R14
    hit_nxt = hit_r;
    group_nxt = group_r;
    accept_nxt = accept_r;
    blocked_nxt = blocked_r;
    out_addr_nxt = out_addr_r;
    if (i_req_valid)
    begin
      hit_nxt = multicast_on_r && i_req_posted && (i_req_addr >= base) && (i_req_addr < top); // R07 R24
      group_nxt = hit_nxt ? grp[5:0] : 6'h00;
      accept_nxt = hit_nxt && group_accept_vector_r[grp[5:0]] && active[grp[5:0]]; // R13
      blocked_nxt = hit_nxt && active[grp[5:0]] && !i_req_egress &&
                    (group_send_block_r[grp[5:0]] || // R15
                     (i_req_untranslated && untranslated_send_block_r[grp[5:0]])); // R16
      out_addr_nxt = i_req_addr;
      if (IS_PORT && hit_nxt && i_req_egress && overlay_size_log2_r >= `MGR_OVL_MIN_SIZE) // R20 R21
      begin
        out_addr_nxt = ({overlay_base_r, 6'h00} & ~lo_mask) | (i_req_addr & lo_mask); // R25
      end
    end
  end

  // all state frozen while the clock enable is low
  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      multicast_on_r <= 1'b0;
      configured_group_count_r <= `MGR_RESET_6;
      group_field_lsb_r <= `MGR_RESET_6;
      window_base_r <= '0;
      group_accept_vector_r <= `MGR_RESET_64;
      group_send_block_r <= `MGR_RESET_64;
      untranslated_send_block_r <= `MGR_RESET_64;
      overlay_base_r <= '0;
      overlay_size_log2_r <= `MGR_RESET_6;
      rdata_r <= 32'h0000_0000;
      hit_r <= 1'b0;
      group_r <= 6'h00;
      accept_r <= 1'b0;
      blocked_r <= 1'b0;
      out_addr_r <= `MGR_RESET_64;
    end
    else if (i_clk_en)
    begin
      multicast_on_r <= multicast_on_nxt;
      configured_group_count_r <= configured_group_count_nxt;
      group_field_lsb_r <= group_field_lsb_nxt;
      window_base_r <= window_base_nxt;
      group_accept_vector_r <= group_accept_vector_nxt;
      group_send_block_r <= group_send_block_nxt;
      untranslated_send_block_r <= untranslated_send_block_nxt;
      overlay_base_r <= overlay_base_nxt;
      overlay_size_log2_r <= overlay_size_log2_nxt;
      rdata_r <= rdata_nxt;
      hit_r <= hit_nxt;
      group_r <= group_nxt;
      accept_r <= accept_nxt;
      blocked_r <= blocked_nxt;
      out_addr_r <= out_addr_nxt;
    end
  end

  // outputs straight from the registers
  assign o_cfg_rdata = rdata_r;
  assign o_mc_hit = hit_r;
  assign o_mc_group = group_r;
  assign o_mc_accept = accept_r;
  assign o_mc_send_blocked = blocked_r;
  assign o_out_addr = out_addr_r;
endmodule : mgr_routing_regs

// ===== logic/mgr_consts.svh
// offsets, field positions and reset values for the multicast group routing registers
`ifndef MGR_CONSTS_SVH
`define MGR_CONSTS_SVH
`define MGR_OFF_CAP_CTRL 12'h004
`define MGR_OFF_BASE_LO 12'h008
`define MGR_OFF_BASE_HI 12'h00C
`define MGR_OFF_ACCEPT_LO 12'h010
`define MGR_OFF_ACCEPT_HI 12'h014
`define MGR_OFF_BLOCK_LO 12'h018
`define MGR_OFF_BLOCK_HI 12'h01C
`define MGR_OFF_UNTR_LO 12'h020
`define MGR_OFF_UNTR_HI 12'h024
`define MGR_OFF_OVL_LO 12'h028
`define MGR_OFF_OVL_HI 12'h02C
`define MGR_CTRL_ENABLE_BIT 15
`define MGR_CAP_CRC_BIT 15
`define MGR_BASE_LSB 12
`define MGR_OVL_BASE_LSB 6
`define MGR_OVL_MIN_SIZE 6'h06
`define MGR_RESET_64 64'h0000_0000_0000_0000
`define MGR_RESET_6 6'h00
`endif

// ===== logic/mgr_pkg.sv
// types shared by the multicast group routing registers
package mgr_pkg;
  typedef enum logic [1:0] {
    MGR_PORT_ENDPOINT,
    MGR_PORT_SWITCH,
    MGR_PORT_ROOT
  } mgr_port_kind_t;
  typedef logic [63:0] mgr_addr_t;
endpackage : mgr_pkg

// ===== tb/mgr_chk.sv
// port checker for the multicast group routing registers
`timescale 1ns/1ps
module mgr_chk (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_clk_en,
  input wire logic i_cfg_wr,
  input wire logic i_cfg_rd,
  input wire logic [11:0] i_cfg_addr,
  input wire logic [31:0] i_cfg_wdata,
  input wire logic [3:0] i_cfg_be,
  input wire logic [31:0] o_cfg_rdata,
  input wire logic i_req_valid,
  input wire logic i_req_posted,
  input wire logic i_req_untranslated,
  input wire logic i_req_egress,
  input wire logic [63:0] i_req_addr,
  input wire logic o_mc_hit,
  input wire logic [5:0] o_mc_group,
  input wire logic o_mc_accept,
  input wire logic o_mc_send_blocked,
  input wire logic [63:0] o_out_addr
);
  logic en_r;
  logic en_nxt;
  // shadow of the enable bit
  always_comb
  begin
    en_nxt = en_r;
    if (i_clk_en && i_cfg_wr && i_cfg_addr == 12'h004 && i_cfg_be[3])
      en_nxt = i_cfg_wdata[31];
  end
  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
      en_r <= 1'b0;
    else
      en_r <= en_nxt;
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  sequence s_take; i_clk_en && i_req_valid; endsequence
  sequence s_idle; !(i_clk_en && i_req_valid); endsequence
  a_off_no_hit: assert property (s_take ##0 !en_r |=> !o_mc_hit) else $error("hit while off");
  a_nonposted_miss: assert property (s_take ##0 !i_req_posted |=> !o_mc_hit) else $error("nonposted hit");
  a_miss_addr_pass: assert property (s_take ##1 !o_mc_hit |-> o_out_addr == $past(i_req_addr))
    else $error("miss address changed");
  a_low_bits_kept: assert property (s_take |=> o_out_addr[5:0] == $past(i_req_addr[5:0]))
    else $error("low address bits changed");
  a_accept_hit: assert property (o_mc_accept |-> o_mc_hit) else $error("accept without hit");
  a_block_hit: assert property (o_mc_send_blocked |-> o_mc_hit) else $error("block without hit");
  a_egress_unblocked: assert property (s_take ##0 i_req_egress |=> !o_mc_send_blocked)
    else $error("egress blocked");
  a_miss_group_zero: assert property (!o_mc_hit |-> o_mc_group == 6'h00) else $error("group on miss");
  a_outputs_hold: assert property (s_idle |=> $stable(o_mc_hit) && $stable(o_mc_group) && $stable(o_out_addr))
    else $error("outputs moved while idle");
  a_rdata_hold: assert property (!(i_clk_en && i_cfg_rd) |=> $stable(o_cfg_rdata))
    else $error("read data moved");
endmodule : mgr_chk
bind mgr_routing_regs mgr_chk mgr_chk_i (.i_clock, .i_nrst, .i_clk_en, .i_cfg_wr, .i_cfg_rd, .i_cfg_addr,
  .i_cfg_wdata, .i_cfg_be, .o_cfg_rdata, .i_req_valid, .i_req_posted, .i_req_untranslated, .i_req_egress,
  .i_req_addr, .o_mc_hit, .o_mc_group, .o_mc_accept, .o_mc_send_blocked, .o_out_addr);

// ===== tb/mgr_link_model.sv
// link partner model presenting requests to the routing block
`timescale 1ns/1ps
module mgr_link_model (
  input wire logic i_clock,
  input wire logic i_go,
  input wire logic [66:0] i_req,
  output logic o_valid,
  output logic o_posted,
  output logic o_untranslated,
  output logic o_egress,
  output logic [63:0] o_addr
);
  logic [63:0] last_r = 64'h0;
  always_ff @(posedge i_clock)
  begin
    if (i_go)
      last_r <= i_req[63:0];
  end
  // idle lines show the inverse of the last request, never a stale copy
  assign o_valid = i_go;
  assign {o_posted, o_untranslated, o_egress} = i_go ? i_req[66:64] : ~i_req[66:64];
  assign o_addr = i_go ? i_req[63:0] : ~last_r;
endmodule : mgr_link_model

// ===== tb/tb_top.sv
// self-checking bench for the multicast group routing registers
`timescale 1ns/1ps
module tb_top;
  localparam logic [63:0] BASE = 64'h0000_0001_0000_0000;
  localparam logic [3:0] ACC = 4'h5, BLK = 4'h2, UNT = 4'h8;
  localparam logic [63:0] CORN [4] = '{BASE - 64'h1, BASE, BASE + 64'h3FFF, BASE + 64'h4000};
  logic i_clock = 1'b0, i_nrst = 1'b0, i_clk_en = 1'b1, i_cfg_wr = 1'b0, i_cfg_rd = 1'b0, go = 1'b0;
  logic [11:0] i_cfg_addr = 12'h000;
  logic [31:0] i_cfg_wdata = 32'h0;
  logic [3:0] i_cfg_be = 4'h0;
  logic [66:0] req = '0, r;
  logic [72:0] prev;
  logic [31:0] o_cfg_rdata;
  logic i_req_valid, i_req_posted, i_req_untranslated, i_req_egress, o_mc_hit, o_mc_accept, o_mc_send_blocked;
  logic [63:0] i_req_addr, o_out_addr, seed = 64'h3, ovl = 64'h0000_0002_0000_0000;
  logic [5:0] o_mc_group, osz = 6'h05;
  int fails = 0, n_checks = 0;
  initial forever #10 i_clock = ~i_clock;
  mgr_link_model mgr_link_model_i (.i_clock, .i_go(go), .i_req(req), .o_valid(i_req_valid), .o_posted(i_req_posted),
    .o_untranslated(i_req_untranslated), .o_egress(i_req_egress), .o_addr(i_req_addr));
  mgr_routing_regs mgr_routing_regs_i (.i_clock, .i_nrst, .i_clk_en, .i_cfg_wr, .i_cfg_rd, .i_cfg_addr, .i_cfg_wdata,
    .i_cfg_be, .o_cfg_rdata, .i_req_valid, .i_req_posted, .i_req_untranslated, .i_req_egress, .i_req_addr,
    .o_mc_hit, .o_mc_group, .o_mc_accept, .o_mc_send_blocked, .o_out_addr);
  function automatic logic [63:0] xs(input logic [63:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 7);
    return s ^ (s << 17);
  endfunction : xs
  function automatic logic [72:0] expect_req(input logic [66:0] q, input logic en);
    logic [63:0] a, off, m;
    logic h;
    logic [5:0] g;
    a = q[63:0];
    off = a - BASE;
    h = en && q[66] && a >= BASE && off < 64'h4000;
    g = h ? off[17:12] : 6'h00;
    m = (64'h1 << osz) - 64'h1;
    if (h && q[64] && osz >= 6'h06)
      a = (ovl & ~m) | (a & m);
    return {h, g, h && ACC[g[1:0]], h && !q[64] && (BLK[g[1:0]] || (q[65] && UNT[g[1:0]])), a};
  endfunction : expect_req
  task automatic chk(input string nm, input logic [72:0] seen, input logic [72:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic cfg(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge i_clock);
    i_cfg_wr <= w;
    i_cfg_rd <= !w;
    i_cfg_addr <= a;
    i_cfg_wdata <= d;
    i_cfg_be <= b;
    @(posedge i_clock);
    i_cfg_wr <= 1'b0;
    i_cfg_rd <= 1'b0;
    @(negedge i_clock);
  endtask : cfg
  task automatic send(input logic [66:0] q, input logic en);
    @(posedge i_clock);
    go <= 1'b1;
    req <= q;
    @(posedge i_clock);
    go <= 1'b0;
    @(negedge i_clock);
    prev = expect_req(q, en);
    chk("request", {o_mc_hit, o_mc_group, o_mc_accept, o_mc_send_blocked, o_out_addr}, prev);
  endtask : send
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up
  initial
  begin
    #1ms;
    fails++;
    wrap_up();
  end
  initial
  begin
    repeat (20) @(posedge i_clock);
    i_nrst <= 1'b1;
    cfg(1'b0, 12'h004, 32'h0, 4'h0);
    chk("capability", 73'(o_cfg_rdata), 73'h003F);
    for (int o = 8; o <= 48; o += 4)
    begin
      cfg(1'b0, 12'(o), 32'h0, 4'h0);
      chk("register reset", 73'(o_cfg_rdata), 73'h0);
    end
    cfg(1'b1, 12'h008, 32'h0000_000C, 4'hF);
    cfg(1'b1, 12'h00C, BASE[63:32], 4'hF);
    cfg(1'b1, 12'h010, 32'h0000_0025, 4'hF);
    cfg(1'b1, 12'h018, 32'h0000_0042, 4'hF);
    cfg(1'b1, 12'h020, 32'h0000_0008, 4'hF);
    cfg(1'b1, 12'h028, 32'h0000_0005, 4'hF);
    cfg(1'b1, 12'h02C, ovl[63:32], 4'hF);
    cfg(1'b1, 12'h004, 32'h0003_FFFF, 4'hF);
    send({3'h4, BASE}, 1'b0);
    cfg(1'b0, 12'h004, 32'h0, 4'h0);
    chk("control", 73'(o_cfg_rdata), 73'h0003_003F);
    cfg(1'b0, 12'h008, 32'h0, 4'h0);
    chk("base", 73'(o_cfg_rdata), 73'h000C);
    cfg(1'b1, 12'h004, 32'h8003_0000, 4'hC);
    cfg(1'b0, 12'h004, 32'h0, 4'h0);
    chk("enabled", 73'(o_cfg_rdata), 73'h8003_003F);
    for (int i = 0; i < 200; i++)
    begin
      if (i == 100)
      begin
        osz = 6'h10;
        cfg(1'b1, 12'h028, 32'h0000_0010, 4'hF);
      end
      seed = xs(seed);
      r = {seed[42:40], BASE - 64'h1000 + 64'(seed[31:0] % 32'h6000)};
      if (i % 100 < 4)
        r = {1'b1, seed[41:40], CORN[i % 4]};
      send(r, 1'b1);
    end
    @(posedge i_clock);
    i_clk_en <= 1'b0;
    go <= 1'b1;
    req <= {3'h4, BASE + 64'h1000};
    @(posedge i_clock);
    go <= 1'b0;
    i_clk_en <= 1'b1;
    @(negedge i_clock);
    chk("frozen", {o_mc_hit, o_mc_group, o_mc_accept, o_mc_send_blocked, o_out_addr}, prev);
    cfg(1'b1, 12'h004, 32'h0003_0000, 4'hC);
    send({3'h4, BASE + 64'h2000}, 1'b0);
    @(posedge i_clock);
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_nrst <= 1'b1;
    @(negedge i_clock);
    chk("reset outputs", {o_mc_hit, o_mc_group, o_mc_accept, o_mc_send_blocked, o_out_addr}, 73'h0);
    cfg(1'b0, 12'h004, 32'h0, 4'h0);
    chk("reset control", 73'(o_cfg_rdata), 73'h003F);
    cfg(1'b0, 12'h00C, 32'h0, 4'h0);
    chk("reset base", 73'(o_cfg_rdata), 73'h0);
    cfg(1'b0, 12'h010, 32'h0, 4'h0);
    chk("reset accept", 73'(o_cfg_rdata), 73'h0);
    cfg(1'b0, 12'h02C, 32'h0, 4'h0);
    chk("reset overlay", 73'(o_cfg_rdata), 73'h0);
    wrap_up();
  end
endmodule : tb_top
